// ### shared/erxhm_pkg.sv
// Package with register map, field layout and reset values for the receive filter config block.
package erxhm_pkg;

    // Register offsets on the plain register port (byte addresses, one word each).
    localparam logic [7:0] OFS_HASH_LOW    = 8'h00;
    localparam logic [7:0] OFS_HASH_HIGH   = 8'h04;
    localparam logic [7:0] OFS_PMASK_LOW   = 8'h08;
    localparam logic [7:0] OFS_PMASK_HIGH  = 8'h0C;
    localparam logic [7:0] OFS_GUARD_STAT  = 8'h10;

    // Reset values.
    localparam logic [31:0] RST_HASH_LOW   = 32'h0000_0000;
    localparam logic [31:0] RST_HASH_HIGH  = 32'h0000_0000;
    localparam logic [31:0] RST_PMASK_LOW  = 32'h0000_0000;
    localparam logic [31:0] RST_PMASK_HIGH = 32'h0000_0000;

    // Guard status register field positions.
    localparam int GUARD_HASH_LOCK_BIT  = 0;
    localparam int GUARD_PMASK_LOCK_BIT = 1;
    localparam int GUARD_DROP_BIT       = 2;

    // Filter configuration as it reaches the receive path.
    typedef struct packed {
        logic [63:0] hash_table_bits;
        logic [63:0] pattern_mask_bits;
    } erxhm_cfg_type;

    // Protection inputs sampled from the controller's control registers.
    typedef struct packed {
        logic       receive_enable_bit;
        logic       hash_filter_enable;
        logic [3:0] pattern_match_mode;
    } erxhm_guard_type;

endpackage

// ### verification/erxhm_regs_bench.sv
// Self-checking bench for the receive hash table and pattern mask registers.
`timescale 1ns/1ps

module erxhm_regs_bench;
    logic                       i_clk;
    logic                       i_nrst;
    logic [7:0]                 i_addr;
    logic [31:0]                i_wdata;
    logic                       i_wr;
    logic                       i_rd;
    logic [31:0]                o_rdata;
    erxhm_pkg::erxhm_guard_type i_guard;
    erxhm_pkg::erxhm_cfg_type   o_rx_cfg;
    int                         miscompares = 0;
    int                         tests_run = 0;

    erxhm_regs dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_guard(i_guard), .o_rx_cfg(o_rx_cfg));

    // Free-running 100 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d.", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Compares a seen value with an expected one; wide enough for a whole table.
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h, expected %h", $time, what, seen, exp);
        end
    endtask

    // One write cycle; returns after the updated outputs have settled.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
        #1;
    endtask

    // One read cycle; the data is valid only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 check(o_rdata, exp, what);
    endtask

    // Sets the protection levels right after an edge.
    task automatic guard(input logic en, input logic hen, input logic [3:0] mode);
        @(posedge i_clk);
        i_guard <= {en, hen, mode};
    endtask

    // All four table words clear to zero and so does the filter configuration.
    task automatic test_reset();
        check(o_rx_cfg.hash_table_bits, 64'h0, "hash at reset");
        check(o_rx_cfg.pattern_mask_bits, 64'h0, "mask at reset");
        for (int k = 0; k < 4; k++) rd(8'(4 * k), 32'h0, "reset value");
    endtask

    // Byte n of each table must land in bits 8n+7:8n of the 64-bit value.
    task automatic test_map();
        wr(8'h00, 32'h0302_0100);
        wr(8'h04, 32'h0706_0504);
        check(o_rx_cfg.hash_table_bits, 64'h0706_0504_0302_0100, "hash map");
        wr(8'h08, 32'h1312_1110);
        wr(8'h0C, 32'h1716_1514);
        check(o_rx_cfg.pattern_mask_bits, 64'h1716_1514_1312_1110, "mask map");
        rd(8'h04, 32'h0706_0504, "hash high read");
        rd(8'h08, 32'h1312_1110, "mask low read");
    endtask

    // Hash locked by receive and hash filter enable; mask stays open with mode zero.
    task automatic test_hash_lock();
        guard(1'b1, 1'b1, 4'h0);
        wr(8'h00, 32'hFFFF_FFFF);
        check(o_rx_cfg.hash_table_bits, 64'h0706_0504_0302_0100, "hash locked");
        wr(8'h08, 32'hAAAA_5555);
        check(o_rx_cfg.pattern_mask_bits, 64'h1716_1514_AAAA_5555, "mask open");
        rd(8'h10, 32'h0000_0005, "drop flagged");
        rd(8'h10, 32'h0000_0001, "drop cleared");
        guard(1'b1, 1'b0, 4'h0);
        wr(8'h04, 32'h1234_5678);
        check(o_rx_cfg.hash_table_bits, 64'h1234_5678_0302_0100, "hash open");
    endtask

    // Mask locked by receive enable and a nonzero mode; unmapped places do nothing.
    task automatic test_mask_lock();
        guard(1'b1, 1'b0, 4'h8);
        wr(8'h0C, 32'hDEAD_BEEF);
        check(o_rx_cfg.pattern_mask_bits, 64'h1716_1514_AAAA_5555, "mask locked");
        rd(8'h10, 32'h0000_0006, "mask lock flagged");
        guard(1'b0, 1'b1, 4'hF);
        wr(8'h0C, 32'hC0DE_0001);
        check(o_rx_cfg.pattern_mask_bits, 64'hC0DE_0001_AAAA_5555, "rx off");
        wr(8'h14, 32'hFFFF_FFFF);
        check(o_rx_cfg.hash_table_bits, 64'h1234_5678_0302_0100, "unmapped wr");
        rd(8'h20, 32'h0, "unmapped read");
    endtask

    // Main sequence: hold reset for 20 cycles, then run the scenarios.
    initial begin
        i_nrst  = 1'b0;
        i_addr  = 8'h00;
        i_wdata = 32'h0;
        i_wr    = 1'b0;
        i_rd    = 1'b0;
        i_guard = '0;
        repeat (20) @(posedge i_clk);
        i_nrst <= 1'b1;
        test_reset();
        test_map();
        test_hash_lock();
        test_mask_lock();
        print_verdict();
    end

    // Watchdog: the scenarios need well under a thousand cycles.
    initial begin
        #20000;
        miscompares++;
        print_verdict();
    end
endmodule

// ### verilog/erxhm_regs.sv
// Receive hash table and pattern match mask registers with change protection.
//
// Operation
// RL1: Hash table low word holds bytes 0-3.
// RL2: Hash table high word holds bytes 4-7.
// RL3: Contents drive receive filtering only, never transmit.
// RL4: Software changes hash only when unprotected.
// RL5: Mask low word holds bytes 0-3.
// RL6: Mask high word holds bytes 4-7.
// RL7: Software changes mask only when unprotected.
// RL8: Writes while protected are dropped silently; the code drops them but sets a sticky drop flag in the status word.
`timescale 1ns/1ps

module erxhm_regs (
    // Clock and reset.
    input  wire logic                     i_clk,
    input  wire logic                     i_nrst,
    // Register port.
    input  wire logic [7:0]               i_addr,
    input  wire logic [31:0]              i_wdata,
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    output logic      [31:0]              o_rdata,
    // Protection levels from the controller control registers.
    input  wire erxhm_pkg::erxhm_guard_type i_guard,
    // Configuration to the receive filter.
    output erxhm_pkg::erxhm_cfg_type      o_rx_cfg
);

    logic [31:0] hash_low_r;
    logic [31:0] hash_high_r;
    logic [31:0] pmask_low_r;
    logic [31:0] pmask_high_r;
    logic [31:0] rdata_r;
    logic        drop_r;
    logic        hash_lock;
    logic        pmask_lock;
    logic        wr_hash_low;
    logic        wr_hash_high;
    logic        wr_pmask_low;
    logic        wr_pmask_high;
    logic        drop_nxt;

    // Protection is a same-clock level, so no synchroniser is needed here.
    assign hash_lock  = i_guard.receive_enable_bit & i_guard.hash_filter_enable;  // RL4
    assign pmask_lock = i_guard.receive_enable_bit &
                        (i_guard.pattern_match_mode != 4'h0);                   // RL7

    // Write decode; a locked register simply refuses the write.
    assign wr_hash_low   = i_wr & (i_addr == erxhm_pkg::OFS_HASH_LOW)   & ~hash_lock;  // RL8
    assign wr_hash_high  = i_wr & (i_addr == erxhm_pkg::OFS_HASH_HIGH)  & ~hash_lock;  // RL8
    assign wr_pmask_low  = i_wr & (i_addr == erxhm_pkg::OFS_PMASK_LOW)  & ~pmask_lock; // RL8
    assign wr_pmask_high = i_wr & (i_addr == erxhm_pkg::OFS_PMASK_HIGH) & ~pmask_lock; // RL8

    // A refused write is remembered so software can see it was lost.
    always_comb begin
        drop_nxt = drop_r;
        if (i_wr && ((i_addr == erxhm_pkg::OFS_HASH_LOW) ||
                     (i_addr == erxhm_pkg::OFS_HASH_HIGH)) && hash_lock) begin
            drop_nxt = 1'b1;
        end else if (i_wr && ((i_addr == erxhm_pkg::OFS_PMASK_LOW) ||
                              (i_addr == erxhm_pkg::OFS_PMASK_HIGH)) && pmask_lock) begin
            drop_nxt = 1'b1;
        end else if (i_rd && (i_addr == erxhm_pkg::OFS_GUARD_STAT)) begin
            drop_nxt = 1'b0;
        end
    end

    // Hash table words.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            hash_low_r  <= erxhm_pkg::RST_HASH_LOW;
            hash_high_r <= erxhm_pkg::RST_HASH_HIGH;
        end else begin
            if (wr_hash_low) begin
                hash_low_r <= i_wdata;   // RL1
            end
            if (wr_hash_high) begin
                hash_high_r <= i_wdata;  // RL2
            end
        end
    end

    // Pattern mask words, byte n of the mask in bits 8n+7:8n.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pmask_low_r  <= erxhm_pkg::RST_PMASK_LOW;
            pmask_high_r <= erxhm_pkg::RST_PMASK_HIGH;
        end else begin
            if (wr_pmask_low) begin
                pmask_low_r <= i_wdata;   // RL5
            end
            if (wr_pmask_high) begin
                pmask_high_r <= i_wdata;  // RL6
            end
        end
    end

    // Sticky drop flag; a new refusal in the read cycle wins over the clear.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            drop_r <= 1'b0;
        end else begin
            drop_r <= drop_nxt;
        end
    end

    // Read data stand for exactly the cycle after the read strobe.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rdata_r <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                erxhm_pkg::OFS_HASH_LOW:   rdata_r <= hash_low_r;
                erxhm_pkg::OFS_HASH_HIGH:  rdata_r <= hash_high_r;
                erxhm_pkg::OFS_PMASK_LOW:  rdata_r <= pmask_low_r;
                erxhm_pkg::OFS_PMASK_HIGH: rdata_r <= pmask_high_r;
                erxhm_pkg::OFS_GUARD_STAT: begin
                    rdata_r <= 32'h0000_0000;
                    rdata_r[erxhm_pkg::GUARD_HASH_LOCK_BIT]  <= hash_lock;
                    rdata_r[erxhm_pkg::GUARD_PMASK_LOCK_BIT] <= pmask_lock;
                    rdata_r[erxhm_pkg::GUARD_DROP_BIT]       <= drop_r;
                end
                default:                   rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign o_rdata = rdata_r;

    // The table only feeds the receive filter; nothing here touches transmit.
    assign o_rx_cfg.hash_table_bits   = {hash_high_r, hash_low_r};    // RL3
    assign o_rx_cfg.pattern_mask_bits = {pmask_high_r, pmask_low_r}; // RL3

    // Assertions.
    a_hash_low_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
        wr_hash_low |=> o_rx_cfg.hash_table_bits[31:0] == $past(i_wdata))  // RL1
        else $error("hash low word not written");
    a_hash_high_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
        wr_hash_high |=> o_rx_cfg.hash_table_bits[63:32] == $past(i_wdata))  // RL2
        else $error("hash high word not written");
    a_pmask_low_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
        wr_pmask_low |=> o_rx_cfg.pattern_mask_bits[7:0] == $past(i_wdata[7:0]))  // RL5
        else $error("mask low word not written");
    a_pmask_high_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
        wr_pmask_high |=> o_rx_cfg.pattern_mask_bits[63:56] == $past(i_wdata[31:24]))  // RL6
        else $error("mask high word not written");
    a_hash_lock_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_guard.receive_enable_bit && i_guard.hash_filter_enable)
        |=> $stable(o_rx_cfg.hash_table_bits))  // RL4
        else $error("hash changed while locked");
    a_pmask_lock_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_guard.receive_enable_bit && i_guard.pattern_match_mode != 4'h0)
        |=> $stable(o_rx_cfg.pattern_mask_bits))  // RL7
        else $error("mask changed while locked");
    a_locked_write_drop: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_wr && hash_lock && i_addr == erxhm_pkg::OFS_HASH_LOW)
        |=> drop_r && $stable(hash_low_r))  // RL8
        else $error("locked write not dropped");
    a_read_hash_high: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_rd && i_addr == erxhm_pkg::OFS_HASH_HIGH && !i_wr)
        |=> o_rdata == $past(hash_high_r) ##1 (o_rdata == 32'h0000_0000 || $past(i_rd)))  // RL2
        else $error("hash high readback wrong");
    a_cfg_rx_only: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !(i_wr || i_rd) |=> $stable(o_rx_cfg))  // RL3
        else $error("config changed without access");

    // Reset must clear every stored word and the read port, whatever came before.
    a_reset_clears: assert property (@(posedge i_clk)
        !i_nrst |=> (o_rx_cfg == '0) && (o_rdata == 32'h0000_0000))  // RL1
        else $error("reset did not clear registers");

    // The other three words must also keep their value when a write is refused.
    a_locked_hash_high: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_wr && hash_lock && i_addr == erxhm_pkg::OFS_HASH_HIGH)
        |=> drop_r && $stable(hash_high_r))  // RL8
        else $error("locked hash high write not dropped");
    a_locked_pmask_low: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_wr && pmask_lock && i_addr == erxhm_pkg::OFS_PMASK_LOW)
        |=> drop_r && $stable(pmask_low_r))  // RL8
        else $error("locked mask low write not dropped");
    a_locked_pmask_high: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_wr && pmask_lock && i_addr == erxhm_pkg::OFS_PMASK_HIGH)
        |=> drop_r && $stable(pmask_high_r))  // RL8
        else $error("locked mask high write not dropped");

    // Reading the status word clears the sticky flag when no refusal competes.
    a_drop_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_rd && !i_wr && i_addr == erxhm_pkg::OFS_GUARD_STAT) |=> !drop_r)  // RL8
        else $error("drop flag not cleared by status read");
    a_status_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_rd && i_addr == erxhm_pkg::OFS_GUARD_STAT)
        |=> o_rdata[2:0] == {$past(drop_r), $past(pmask_lock), $past(hash_lock)})  // RL8
        else $error("status readback wrong");

    // Readback of the remaining words, one cycle after the strobe.
    a_read_hash_low: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_rd && i_addr == erxhm_pkg::OFS_HASH_LOW)
        |=> o_rdata == $past(hash_low_r))  // RL1
        else $error("hash low readback wrong");
    a_read_pmask_low: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_rd && i_addr == erxhm_pkg::OFS_PMASK_LOW)
        |=> o_rdata == $past(pmask_low_r))  // RL5
        else $error("mask low readback wrong");
    a_read_pmask_high: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_rd && i_addr == erxhm_pkg::OFS_PMASK_HIGH)
        |=> o_rdata == $past(pmask_high_r))  // RL6
        else $error("mask high readback wrong");

    // Without a read strobe the port shows zero, so stale data never lingers.
    a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_rd |=> o_rdata == 32'h0000_0000)  // RL1
        else $error("read data present without read");

    // Per byte lane: byte n of each word must land in bits 8n+7:8n of its half.
    // Checking lanes one by one catches swapped or shifted bytes that a
    // whole-word compare against the same wiring might miss.
    for (genvar n = 0; n < 4; n++) begin : g_lane
        a_hash_low_lane: assert property (@(posedge i_clk) disable iff (!i_nrst)
            wr_hash_low
            |=> o_rx_cfg.hash_table_bits[8*n +: 8] == $past(i_wdata[8*n +: 8]))  // RL1
            else $error("hash low byte lane wrong");
        a_hash_high_lane: assert property (@(posedge i_clk) disable iff (!i_nrst)
            wr_hash_high
            |=> o_rx_cfg.hash_table_bits[32+8*n +: 8] == $past(i_wdata[8*n +: 8]))  // RL2
            else $error("hash high byte lane wrong");
        a_pmask_low_lane: assert property (@(posedge i_clk) disable iff (!i_nrst)
            wr_pmask_low
            |=> o_rx_cfg.pattern_mask_bits[8*n +: 8] == $past(i_wdata[8*n +: 8]))  // RL5
            else $error("mask low byte lane wrong");
        a_pmask_high_lane: assert property (@(posedge i_clk) disable iff (!i_nrst)
            wr_pmask_high
            |=> o_rx_cfg.pattern_mask_bits[32+8*n +: 8] == $past(i_wdata[8*n +: 8]))  // RL6
            else $error("mask high byte lane wrong");
    end

endmodule
